// [rtl/wo_consts.vh]
// object indices, reset values, limits and attribute codes of the wrap offset block
// assumes it is included by bare name into each design file that needs it
`ifndef WO_CONSTS_VH
`define WO_CONSTS_VH

// object indices
`define WO_IDX_ENABLE 16'h41C7
`define WO_IDX_RANGE 16'h41C9
`define WO_IDX_RATIO 16'h41CB
`define WO_IDX_STEPS 16'h41CC
`define WO_IDX_DIVS 16'h41CD
`define WO_IDX_STATUS 16'h4FF0

// reset values
`define WO_RST_ENABLE 32'h00000000
`define WO_RST_RANGE 32'h00002710
`define WO_RST_RATIO 32'h00001388
`define WO_RST_STEPS 32'h00000000
`define WO_RST_DIVS 32'h00000001

// accepted write ranges
`define WO_RATIO_MAX 32'h00002710
`define WO_DIVS_MAX 32'h1FFFFFFF
`define WO_STEPS_MIN 32'hE0000000
`define WO_STEPS_MAX 32'h1FFFFFFF

// ratio full scale, 100.00 % in 0.01 % units
`define WO_RATIO_FULL 48'h000000002710

// status bit positions
`define WO_ST_INFO 0
`define WO_ST_ALARM 1

// attribute byte: [0] writable, [2:1] pdo (0 none, 1 rx, 2 tx), [3] saved, [5:4] update class (0 A, 2 C, 3 none)
`define WO_ATTR_CLASS_C 8'h29
`define WO_ATTR_CLASS_A 8'h09
`define WO_ATTR_STATUS 8'h34

// walk pointer of the last saved object of a batch store
`define WO_NV_LAST 3'h4

`endif

// [rtl/wo_div.v]
// unsigned restoring divider, one quotient bit per clock
// assumes start is only raised while busy is low; divide by zero gives all-ones quotient
`timescale 1ns/1ps
module wo_div #(
  parameter W = 32
) (
  input wire ref_clk_in,
  input wire nrst_in,
  input wire start_in,
  input wire [W-1:0] dividend_in,
  input wire [W-1:0] divisor_in,
  output reg busy_out,
  output reg done_out,
  output reg [W-1:0] quot_out,
  output reg [W-1:0] rem_out
);

  reg [W-1:0] dsr_q;
  reg [6:0] cnt_q;
  wire [W:0] trial = {rem_out, quot_out[W-1]} - {1'b0, dsr_q};

  // shift-subtract loop; done pulses one cycle when the last bit lands
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      quot_out <= {W{1'b0}};
      rem_out <= {W{1'b0}};
      dsr_q <= {W{1'b0}};
      cnt_q <= 7'h00;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in && !busy_out)
      begin
        busy_out <= 1'b1;
        quot_out <= dividend_in;
        rem_out <= {W{1'b0}};
        dsr_q <= divisor_in;
        cnt_q <= W[6:0];
      end
      else if (busy_out)
      begin
        if (!trial[W])
        begin
          rem_out <= trial[W-1:0];
          quot_out <= {quot_out[W-2:0], 1'b1};
        end
        else
        begin
          rem_out <= {rem_out[W-2:0], quot_out[W-1]};
          quot_out <= {quot_out[W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 7'h01;
        if (cnt_q == 7'h01)
        begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

endmodule

// [rtl/wo_obj_reg.v]
// one writable object: the stored value seen by the master and the active value used by the logic
// assumes writes are already range checked by the object port decoder
`timescale 1ns/1ps
module wo_obj_reg #(
  parameter [31:0] RST = 32'h00000000,
  parameter IMM = 0
) (
  input wire ref_clk_in,
  input wire nrst_in,
  input wire wr_in,
  input wire [31:0] wdata_in,
  input wire apply_in,
  output reg [31:0] stored_out,
  output reg [31:0] active_out
);

  // class A objects go live on the write, the others wait for apply
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stored_out <= RST;
      active_out <= RST;
    end
    else
    begin
      if (wr_in)
        stored_out <= wdata_in;
      if (IMM != 0 && wr_in)
        active_out <= wdata_in;
      else if (apply_in)
        active_out <= stored_out;
    end
  end

endmodule

// [rtl/wo_top.v]
// wrap offset coordinate logic: offset range, wrap error info and alarm, division marker output
// assumes the object port, position and commands all come from logic on ref_clk_in
`timescale 1ns/1ps
`include "wo_consts.vh"

// Function
// R1: range boundary placed relative to home by ratio then step offset
// R2: ratio offset moves the wrap range toward negative direction
// R3: signed step offset applied after ratio offset
// R4: error info raised when shifted range excludes home
// R5: pending info becomes alarm on power up or configuration
// R6: marker asserted at each equal division boundary counted from home
// R7: division count object accepts 1 to 536870911, default 1
// R8: marker only while wrap enable equals 1
// R9: read-write objects accept writes, read-only objects refuse them
// R10: each object reports its pdo mapping attribute
// R11: batch store copies saved objects to non-volatile memory
// R12: class A applies at once, class C waits for configuration
// R13: master writes ratio 0 to 10000, default 5000
// R14: master writes step offset within signed 30-bit range, default 0
// R15: wrapping only while enabled; invalid range raises error info
// R16: marker pitch is range over division count, one mark at home
// R17: error info is non-fatal; operation continues until escalated; the code outputs the raw position as soon as info is set
module wo_top (
  input wire ref_clk_in,
  input wire nrst_in,
  input wire obj_req_in,
  input wire obj_wr_in,
  input wire [15:0] obj_index_in,
  input wire [31:0] obj_wdata_in,
  input wire config_cmd_in,
  input wire nv_batch_in,
  input wire alarm_reset_in,
  input wire [31:0] pos_steps_in,
  output reg obj_ack_out,
  output reg obj_abort_out,
  output reg [31:0] obj_rdata_out,
  output reg [7:0] obj_attr_out,
  output reg nv_wr_out,
  output reg [15:0] nv_index_out,
  output reg [31:0] nv_data_out,
  output reg [31:0] wrapped_pos_out,
  output reg division_marker_output_out,
  output reg wrap_info_out,
  output reg wrap_alarm_out
);

  // ----------------------------------------
  // object port decode
  // ----------------------------------------
  localparam S_IDLE = 6'h01;
  localparam S_RSTART = 6'h02;
  localparam S_RWAIT = 6'h04;
  localparam S_PSTART = 6'h08;
  localparam S_PWAIT = 6'h10;
  localparam S_CHECK = 6'h20;

  reg [5:0] st_q;
  reg boot_q;
  reg wr_ok;
  reg [7:0] attr_d;
  reg [31:0] rdata_d;
  reg hit_d;
  wire [31:0] en_st, en_act, rng_st, rng_act, rat_st, rat_act, stp_st, stp_act, div_st, div_act;
  wire is_wr = obj_req_in && obj_wr_in;
  wire apply = config_cmd_in || boot_q;

  // range check and readback per index; a refused write never reaches storage
  always @*
  begin
    wr_ok = 1'b0;
    hit_d = 1'b1;
    rdata_d = 32'h00000000;
    attr_d = `WO_ATTR_CLASS_C;
    case (obj_index_in)
      `WO_IDX_ENABLE:
      begin
        rdata_d = en_st;
        wr_ok = (obj_wdata_in[31:1] == 31'h00000000);
      end
      `WO_IDX_RANGE:
      begin
        rdata_d = rng_st;
        wr_ok = 1'b1;
      end
      `WO_IDX_RATIO:
      begin
        rdata_d = rat_st;
        wr_ok = (obj_wdata_in <= `WO_RATIO_MAX);
      end
      `WO_IDX_STEPS:
      begin
        rdata_d = stp_st;
        wr_ok = ($signed(obj_wdata_in) >= $signed(`WO_STEPS_MIN)) &&
                ($signed(obj_wdata_in) <= $signed(`WO_STEPS_MAX));
      end
      `WO_IDX_DIVS:
      begin
        // R7: division count limits
        rdata_d = div_st;
        attr_d = `WO_ATTR_CLASS_A;
        wr_ok = (obj_wdata_in != 32'h00000000) && (obj_wdata_in <= `WO_DIVS_MAX);
      end
      `WO_IDX_STATUS:
      begin
        // R10: tx mapping attribute
        rdata_d = 32'h00000000;
        rdata_d[`WO_ST_INFO] = wrap_info_out;
        rdata_d[`WO_ST_ALARM] = wrap_alarm_out;
        attr_d = `WO_ATTR_STATUS;
      end
      default:
      begin
        hit_d = 1'b0;
        attr_d = 8'h00;
      end
    endcase
  end

  wire we_ok = is_wr && wr_ok;
  wire we_en = we_ok && obj_index_in == `WO_IDX_ENABLE;
  wire we_rng = we_ok && obj_index_in == `WO_IDX_RANGE;
  wire we_rat = we_ok && obj_index_in == `WO_IDX_RATIO;
  wire we_stp = we_ok && obj_index_in == `WO_IDX_STEPS;
  wire we_div = we_ok && obj_index_in == `WO_IDX_DIVS;

  // answer one cycle after the request; abort for unmapped, read-only or out-of-range writes
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      obj_ack_out <= 1'b0;
      obj_abort_out <= 1'b0;
      obj_rdata_out <= 32'h00000000;
      obj_attr_out <= 8'h00;
    end
    else
    begin
      // R9: read-only refusal
      obj_ack_out <= obj_req_in && hit_d && (!obj_wr_in || wr_ok);
      obj_abort_out <= obj_req_in && (!hit_d || (obj_wr_in && !wr_ok));
      obj_rdata_out <= (obj_req_in && !obj_wr_in) ? rdata_d : 32'h00000000;
      obj_attr_out <= obj_req_in ? attr_d : 8'h00;
    end
  end

  // ----------------------------------------
  // object storage
  // ----------------------------------------
  // R12: class C objects apply on configuration
  wo_obj_reg #(.RST(`WO_RST_ENABLE), .IMM(0)) u_en (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .wr_in(we_en), .wdata_in(obj_wdata_in), .apply_in(apply), .stored_out(en_st), .active_out(en_act));
  wo_obj_reg #(.RST(`WO_RST_RANGE), .IMM(0)) u_rng (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .wr_in(we_rng), .wdata_in(obj_wdata_in), .apply_in(apply), .stored_out(rng_st), .active_out(rng_act));
  wo_obj_reg #(.RST(`WO_RST_RATIO), .IMM(0)) u_rat (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .wr_in(we_rat), .wdata_in(obj_wdata_in), .apply_in(apply), .stored_out(rat_st), .active_out(rat_act));
  wo_obj_reg #(.RST(`WO_RST_STEPS), .IMM(0)) u_stp (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .wr_in(we_stp), .wdata_in(obj_wdata_in), .apply_in(apply), .stored_out(stp_st), .active_out(stp_act));
  // R12: class A applies at once
  wo_obj_reg #(.RST(`WO_RST_DIVS), .IMM(1)) u_div (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .wr_in(we_div), .wdata_in(obj_wdata_in), .apply_in(apply), .stored_out(div_st), .active_out(div_act));

  // ----------------------------------------
  // configuration pass
  // ----------------------------------------
  reg [31:0] lower_q;
  reg [31:0] pitch_q;
  reg div_dirty_q;
  reg cfg_pend_q;
  reg boot_pass_q;
  wire cfg_done;
  wire [47:0] cfg_quot;
  wire [47:0] ratio_prod = {16'h0000, rng_act} * {34'h000000000, rat_act[13:0]};
  wire cfg_start = (st_q == S_RSTART) || (st_q == S_PSTART);
  wire [47:0] cfg_dividend = (st_q == S_RSTART) ? ratio_prod : {16'h0000, rng_act};
  wire [47:0] cfg_divisor = (st_q == S_RSTART) ? `WO_RATIO_FULL : {16'h0000, div_act};

  wo_div #(.W(48)) u_cfg_div (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .start_in(cfg_start),
    .dividend_in(cfg_dividend), .divisor_in(cfg_divisor), .busy_out(), .done_out(cfg_done),
    .quot_out(cfg_quot), .rem_out());

  // home lies inside [lower, lower + range) only when lower <= 0 < lower + range
  wire [32:0] upper = {lower_q[31], lower_q} + {1'b0, rng_act};
  wire home_in = (lower_q[31] || lower_q == 32'h00000000) && !upper[32] && (upper != 33'h000000000);
  // R15: enabled range validity
  wire bad_cfg = en_act[0] && ((rng_act == 32'h00000000) || !home_in);

  // sequence: ratio offset, then marker pitch, then the home check
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_q <= S_IDLE;
      boot_q <= 1'b1;
      lower_q <= 32'h00000000;
      pitch_q <= 32'h00000000;
      div_dirty_q <= 1'b0;
      cfg_pend_q <= 1'b0;
      boot_pass_q <= 1'b1;
      wrap_info_out <= 1'b0;
      wrap_alarm_out <= 1'b0;
    end
    else
    begin
      boot_q <= 1'b0;
      // a configuration landing during a pass reruns it once the pass is over
      cfg_pend_q <= (apply || cfg_pend_q) && (st_q != S_IDLE);
      case (st_q)
        S_IDLE:
        begin
          if (apply || cfg_pend_q)
            st_q <= S_RSTART;
          else if (div_dirty_q)
          begin
            div_dirty_q <= 1'b0;
            st_q <= S_PSTART;
          end
        end
        S_RSTART:
          st_q <= S_RWAIT;
        S_RWAIT:
        begin
          if (cfg_done)
          begin
            // R2: ratio moves range negative
            // R3: step offset after ratio
            lower_q <= stp_act - cfg_quot[31:0];
            st_q <= S_PSTART;
          end
        end
        S_PSTART:
          st_q <= S_PWAIT;
        S_PWAIT:
        begin
          if (cfg_done)
          begin
            // R16: pitch is range over count
            pitch_q <= (div_act > rng_act) ? 32'h00000000 : cfg_quot[31:0];
            st_q <= S_CHECK;
          end
        end
        S_CHECK:
          st_q <= S_IDLE;
        default:
          st_q <= S_IDLE;
      endcase
      // set after the case so a write in the consuming cycle is not lost
      if (we_div)
        div_dirty_q <= 1'b1;
      // the first pass after reset stands for the power-up check
      if (st_q == S_CHECK)
        boot_pass_q <= 1'b0;
      // R4: info follows the home check
      if (st_q == S_CHECK)
        wrap_info_out <= bad_cfg;
      // R5: escalate pending info; set wins over reset
      if ((config_cmd_in && wrap_info_out) || (boot_q && wrap_info_out))
        wrap_alarm_out <= 1'b1;
      else if (st_q == S_CHECK && bad_cfg && boot_pass_q)
        wrap_alarm_out <= 1'b1;
      else if (alarm_reset_in && !wrap_info_out)
        wrap_alarm_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // wrapped coordinate and marker
  // ----------------------------------------
  // R1: boundary at lower_q, home referenced
  wire [32:0] rel = {pos_steps_in[31], pos_steps_in} - {lower_q[31], lower_q};
  wire [32:0] rel_abs = rel[32] ? (33'h000000000 - rel) : rel;
  wire [31:0] pos_abs = pos_steps_in[31] ? (32'h00000000 - pos_steps_in) : pos_steps_in;
  wire w_busy, w_done, m_busy, m_done;
  wire [32:0] w_rem;
  wire [31:0] m_rem;
  reg w_neg_q;
  reg [31:0] w_pos_q;

  // samplers restart as soon as they are idle; a sample lags the position by about 34 cycles
  wo_div #(.W(33)) u_wrap_div (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .start_in(!w_busy),
    .dividend_in(rel_abs), .divisor_in({1'b0, rng_act}), .busy_out(w_busy), .done_out(w_done),
    .quot_out(), .rem_out(w_rem));
  wo_div #(.W(32)) u_mark_div (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .start_in(!m_busy),
    .dividend_in(pos_abs), .divisor_in(pitch_q), .busy_out(m_busy), .done_out(m_done),
    .quot_out(), .rem_out(m_rem));

  wire [31:0] w_off = (w_neg_q && w_rem != 33'h000000000) ? (rng_act - w_rem[31:0]) : w_rem[31:0];

  // remember the sample's sign and raw value next to the running division
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      w_neg_q <= 1'b0;
      w_pos_q <= 32'h00000000;
      wrapped_pos_out <= 32'h00000000;
      division_marker_output_out <= 1'b0;
    end
    else
    begin
      if (!w_busy)
      begin
        w_neg_q <= rel[32];
        w_pos_q <= pos_steps_in;
      end
      // R15: wrap only when enabled; R17: info alone stops wrapping and passes the raw position
      if (w_done)
        wrapped_pos_out <= (en_act[0] && !wrap_info_out) ? (lower_q + w_off) : w_pos_q;
      // R6: mark on each pitch multiple; R8: only when enabled
      if (m_done)
        division_marker_output_out <= en_act[0] && (pitch_q != 32'h00000000) && (m_rem == 32'h00000000);
    end
  end

  // ----------------------------------------
  // batch non-volatile store
  // ----------------------------------------
  reg nv_busy_q;
  reg [2:0] nv_ptr_q;
  reg [15:0] nv_idx_d;
  reg [31:0] nv_dat_d;

  // saved objects in walk order; status is not saved
  always @*
  begin
    nv_idx_d = `WO_IDX_ENABLE;
    nv_dat_d = en_st;
    case (nv_ptr_q)
      3'h1:
      begin
        nv_idx_d = `WO_IDX_RANGE;
        nv_dat_d = rng_st;
      end
      3'h2:
      begin
        nv_idx_d = `WO_IDX_RATIO;
        nv_dat_d = rat_st;
      end
      3'h3:
      begin
        nv_idx_d = `WO_IDX_STEPS;
        nv_dat_d = stp_st;
      end
      3'h4:
      begin
        nv_idx_d = `WO_IDX_DIVS;
        nv_dat_d = div_st;
      end
      default:
      begin
        nv_idx_d = `WO_IDX_ENABLE;
        nv_dat_d = en_st;
      end
    endcase
  end

  // R11: one saved object per cycle
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      nv_busy_q <= 1'b0;
      nv_ptr_q <= 3'h0;
      nv_wr_out <= 1'b0;
      nv_index_out <= 16'h0000;
      nv_data_out <= 32'h00000000;
    end
    else
    begin
      nv_wr_out <= nv_busy_q;
      if (nv_busy_q)
      begin
        nv_index_out <= nv_idx_d;
        nv_data_out <= nv_dat_d;
        nv_ptr_q <= nv_ptr_q + 3'h1;
        if (nv_ptr_q == `WO_NV_LAST)
          nv_busy_q <= 1'b0;
      end
      else if (nv_batch_in)
      begin
        nv_busy_q <= 1'b1;
        nv_ptr_q <= 3'h0;
      end
    end
  end

endmodule

// [test/wo_top_properties.sv]
// checks of object port answers, escalation and batch store order of the wrap offset block
// assumes it is bound to wo_top and sees only its ports, one clock domain
`timescale 1ns/1ps
module wo_top_properties (
  input wire ref_clk_in,
  input wire nrst_in,
  input wire obj_req_in,
  input wire obj_wr_in,
  input wire [15:0] obj_index_in,
  input wire [31:0] obj_wdata_in,
  input wire alarm_reset_in,
  input wire config_cmd_in,
  input wire obj_ack_out,
  input wire obj_abort_out,
  input wire [31:0] obj_rdata_out,
  input wire [7:0] obj_attr_out,
  input wire nv_wr_out,
  input wire [15:0] nv_index_out,
  input wire wrap_info_out,
  input wire wrap_alarm_out
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  // write request seen on the object port
  wire wr_req = obj_req_in && obj_wr_in;
  a_one_answer: assert property (
    obj_req_in |=> obj_ack_out != obj_abort_out) else $error("access not answered exactly once");
  a_no_stray: assert property (
    !obj_req_in |=> !obj_ack_out && !obj_abort_out) else $error("answer without a request");
  a_write_rdata: assert property (
    wr_req |=> obj_rdata_out == 32'h00000000) else $error("read data returned on a write");
  a_status_ro: assert property (
    wr_req && obj_index_in == 16'h4FF0 |=> obj_abort_out) else $error("status write accepted");
  a_divs_limit: assert property (
    wr_req && obj_index_in == 16'h41CD && (obj_wdata_in == 32'h00000000 || obj_wdata_in > 32'h1FFFFFFF)
    |=> obj_abort_out) else $error("division count out of range accepted");
  a_divs_class: assert property (
    obj_req_in && obj_index_in == 16'h41CD |=> obj_attr_out == 8'h09) else $error("division count attribute");
  a_ratio_attr: assert property (
    obj_req_in && obj_index_in == 16'h41CB |=> obj_attr_out == 8'h29) else $error("offset ratio attribute");
  a_escalate_alarm: assert property (
    config_cmd_in && wrap_info_out |-> ##[1:2] wrap_alarm_out) else $error("pending info not escalated");
  a_alarm_holds: assert property (
    wrap_alarm_out && !alarm_reset_in && !$past(alarm_reset_in) |=> wrap_alarm_out) else $error("alarm dropped");
  a_store_order: assert property (
    $rose(nv_wr_out) |-> nv_index_out == 16'h41C7 ##1 nv_wr_out && nv_index_out == 16'h41C9
    ##1 nv_wr_out && nv_index_out == 16'h41CB ##1 nv_wr_out && nv_index_out == 16'h41CC
    ##1 nv_wr_out && nv_index_out == 16'h41CD ##1 !nv_wr_out) else $error("batch store order");
endmodule

bind wo_top wo_top_properties wo_top_properties_i (
  .ref_clk_in, .nrst_in, .obj_req_in, .obj_wr_in, .obj_index_in, .obj_wdata_in, .alarm_reset_in,
  .config_cmd_in, .obj_ack_out, .obj_abort_out, .obj_rdata_out, .obj_attr_out, .nv_wr_out,
  .nv_index_out, .wrap_info_out, .wrap_alarm_out
);

// [test/wo_master_model.sv]
// network master model: object accesses, command pulses and motor position toward the block
// assumes one access at a time; every change lands 1 ns after a rising edge
`timescale 1ns/1ps
module wo_master_model (
  input wire ref_clk_in,
  input wire obj_ack_in,
  input wire obj_abort_in,
  input wire [31:0] obj_rdata_in,
  input wire [7:0] obj_attr_in,
  output logic obj_req_out,
  output logic obj_wr_out,
  output logic [15:0] obj_index_out,
  output logic [31:0] obj_wdata_out,
  output logic config_cmd_out,
  output logic nv_batch_out,
  output logic alarm_reset_out,
  output logic [31:0] pos_steps_out
);
  // quiet bus at time zero
  initial
  begin
    {obj_req_out, obj_wr_out, config_cmd_out, nv_batch_out, alarm_reset_out} = 5'h00;
    obj_index_out = 16'h0000;
    obj_wdata_out = 32'h00000000;
    pos_steps_out = 32'h00000000;
  end
  task automatic obj_access(input logic w, input logic [15:0] i, input logic [31:0] d,
                            output logic k, output logic b, output logic [31:0] r, output logic [7:0] a);
    @(posedge ref_clk_in);
    #1;
    obj_req_out = 1'b1;
    obj_wr_out = w;
    obj_index_out = i;
    obj_wdata_out = d;
    @(posedge ref_clk_in);
    #1;
    k = obj_ack_in;
    b = obj_abort_in;
    r = obj_rdata_in;
    a = obj_attr_in;
    obj_req_out = 1'b0;
    // idle bus shows inverted values so a stale word never looks live
    obj_index_out = ~i;
    obj_wdata_out = ~d;
  endtask
  // one-cycle command: 0 configuration, 1 batch store, 2 alarm reset
  task automatic pulse(input int sel);
    @(posedge ref_clk_in);
    #1;
    config_cmd_out = (sel == 0);
    nv_batch_out = (sel == 1);
    alarm_reset_out = (sel == 2);
    @(posedge ref_clk_in);
    #1;
    config_cmd_out = 1'b0;
    nv_batch_out = 1'b0;
    alarm_reset_out = 1'b0;
  endtask
  // new motor position, home is zero
  task automatic set_pos(input logic [31:0] p);
    @(posedge ref_clk_in);
    #1;
    pos_steps_out = p;
  endtask
endmodule

// [test/tb_top.sv]
// self-checking bench: object port, batch store, wrap error escalation, wrapped position, marker
// assumes wo_top and wo_master_model are compiled before it
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  wire req, wr, cfg, batch, clr, ack, abort, nv_wr, marker, info, alarm;
  wire [15:0] idx;
  wire [15:0] nv_idx;
  wire [31:0] wdata, pos, rdata, nv_data, wpos;
  wire [7:0] attr;
  localparam logic [31:0] zero = 32'h00000000;
  int mismatches = 0;
  int checks_done = 0;
  // 20 MHz clock
  always #25 ref_clk_in = ~ref_clk_in;
  wo_top wo_top_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .obj_req_in(req), .obj_wr_in(wr),
    .obj_index_in(idx), .obj_wdata_in(wdata), .config_cmd_in(cfg), .nv_batch_in(batch),
    .alarm_reset_in(clr), .pos_steps_in(pos), .obj_ack_out(ack), .obj_abort_out(abort),
    .obj_rdata_out(rdata), .obj_attr_out(attr), .nv_wr_out(nv_wr), .nv_index_out(nv_idx),
    .nv_data_out(nv_data), .wrapped_pos_out(wpos), .division_marker_output_out(marker),
    .wrap_info_out(info), .wrap_alarm_out(alarm));
  wo_master_model wo_master_model_i (.ref_clk_in(ref_clk_in), .obj_ack_in(ack), .obj_abort_in(abort),
    .obj_rdata_in(rdata), .obj_attr_in(attr), .obj_req_out(req), .obj_wr_out(wr), .obj_index_out(idx),
    .obj_wdata_out(wdata), .config_cmd_out(cfg), .nv_batch_out(batch), .alarm_reset_out(clr),
    .pos_steps_out(pos));
  // comparisons, four-state exact
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  // one access; data and attribute only count when accepted, writes return zero data
  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d, input logic ok,
                     input logic [31:0] er, input logic [7:0] ea);
    logic k;
    logic b;
    logic [31:0] r;
    logic [7:0] a;
    wo_master_model_i.obj_access(w, i, d, k, b, r, a);
    cmp_bit(k, ok);
    cmp_bit(b, !ok);
    if (ok)
    begin
      cmp_word(r, w ? zero : er);
      cmp_word({24'h000000, a}, {24'h000000, ea});
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // configuration plus time for the check pass and the samplers
  task automatic reconf();
    wo_master_model_i.pulse(0);
    settle(200);
  endtask
  task automatic pos_case(input logic [31:0] p, input logic [31:0] ew, input logic em);
    wo_master_model_i.set_pos(p);
    settle(150);
    cmp_word(wpos, ew);
    cmp_bit(marker, em);
  endtask
  // batch store: every saved object once, in index order, with its stored value
  task automatic store_check();
    logic [15:0] ei [5];
    logic [31:0] ed [5];
    int n;
    ei = '{16'h41C7, 16'h41C9, 16'h41CB, 16'h41CC, 16'h41CD};
    ed = '{zero, 32'h00002710, 32'h00001388, 32'hE0000000, 32'h1FFFFFFF};
    n = 0;
    wo_master_model_i.pulse(1);
    repeat (10)
    begin
      @(posedge ref_clk_in);
      #1;
      if (nv_wr === 1'b1 && n < 5)
      begin
        cmp_word({16'h0000, nv_idx}, {16'h0000, ei[n]});
        cmp_word(nv_data, ed[n]);
        n++;
      end
    end
    cmp_word(n, 5);
  endtask
  task automatic summarize();
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog, well beyond the roughly 2700 cycles of the sequence
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    mismatches++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk_in);
    #1;
    nrst_in = 1'b1;
    acc(1'b0, 16'h41CB, zero, 1'b1, 32'h00001388, 8'h29);
    acc(1'b0, 16'h41CC, zero, 1'b1, zero, 8'h29);
    acc(1'b0, 16'h41CD, zero, 1'b1, 32'h00000001, 8'h09);
    acc(1'b0, 16'h4FF0, zero, 1'b1, zero, 8'h34);
    acc(1'b1, 16'h4FF0, 32'h00000003, 1'b0, zero, 8'h00);
    acc(1'b0, 16'h1018, zero, 1'b0, zero, 8'h00);
    acc(1'b1, 16'h41CB, 32'h00002711, 1'b0, zero, 8'h00);
    acc(1'b1, 16'h41CD, zero, 1'b0, zero, 8'h00);
    acc(1'b1, 16'h41CD, 32'h20000000, 1'b0, zero, 8'h00);
    acc(1'b1, 16'h41CC, 32'h20000000, 1'b0, zero, 8'h00);
    acc(1'b1, 16'h41CC, 32'hDFFFFFFF, 1'b0, zero, 8'h00);
    acc(1'b0, 16'h41CD, zero, 1'b1, 32'h00000001, 8'h09);
    acc(1'b1, 16'h41CD, 32'h1FFFFFFF, 1'b1, zero, 8'h09);
    acc(1'b1, 16'h41CC, 32'hE0000000, 1'b1, zero, 8'h29);
    acc(1'b0, 16'h41CC, zero, 1'b1, 32'hE0000000, 8'h29);
    store_check();
    acc(1'b1, 16'h41CC, 32'h00001770, 1'b1, zero, 8'h29);
    acc(1'b1, 16'h41C7, 32'h00000001, 1'b1, zero, 8'h29);
    acc(1'b1, 16'h41CD, 32'h00000004, 1'b1, zero, 8'h09);
    wo_master_model_i.set_pos(32'h00000BB8);
    reconf();
    cmp_bit(info, 1'b1);
    cmp_bit(alarm, 1'b0);
    cmp_word(wpos, 32'h00000BB8);
    acc(1'b0, 16'h4FF0, zero, 1'b1, 32'h00000001, 8'h34);
    wo_master_model_i.pulse(0);
    settle(2);
    cmp_bit(alarm, 1'b1);
    settle(150);
    acc(1'b1, 16'h41CC, zero, 1'b1, zero, 8'h29);
    reconf();
    cmp_bit(info, 1'b0);
    cmp_bit(alarm, 1'b1);
    wo_master_model_i.pulse(2);
    settle(2);
    cmp_bit(alarm, 1'b0);
    pos_case(zero, zero, 1'b1);
    pos_case(32'h00001770, 32'hFFFFF060, 1'b0);
    pos_case(32'h000009C4, 32'h000009C4, 1'b1);
    pos_case(32'h000009C5, 32'h000009C5, 1'b0);
    pos_case(32'hFFFFEC78, 32'hFFFFEC78, 1'b1);
    acc(1'b1, 16'h41CD, 32'h00000002, 1'b1, zero, 8'h09);
    pos_case(32'h000009C4, 32'h000009C4, 1'b0);
    acc(1'b1, 16'h41CB, zero, 1'b1, zero, 8'h29);
    reconf();
    pos_case(32'hFFFFFFFF, 32'h0000270F, 1'b0);
    acc(1'b1, 16'h41CC, 32'hFFFFFC18, 1'b1, zero, 8'h29);
    reconf();
    pos_case(32'h0000251C, 32'hFFFFFE0C, 1'b0);
    acc(1'b1, 16'h41C7, zero, 1'b1, zero, 8'h29);
    reconf();
    pos_case(32'h0000251C, 32'h0000251C, 1'b0);
    pos_case(zero, zero, 1'b0);
    summarize();
  end
endmodule
